// >>> hw/icv_core.sv
// Interrupt classification and vector selection with AHB-Lite register slave
//
// Behaviour
// - Maskable requests need I flag, level priority
// - Non-maskable taken regardless of I flag
// - Instruction interrupts are non-maskable software
// - Undefined opcode vectors through first slot
// - Break instruction uses its fixed slot
// - Break high byte FFh uses relocatable entry
// - Software interrupt number 0-63 relocatable entry
// - Numbers 4-31 share peripheral entries
// - Numbers 0-31 push then clear U
// - Return restores U from stack copy
// - Numbers 32-63 leave U unchanged
// - Special interrupts are non-maskable
// - Watchdog, oscillation, voltage share one slot
// - Address match fires before matching instruction
// - Peripheral interrupts are maskable
// - Four-byte vectors; branch to vector address
// - Fixed table slots from FFDCh to FFFFh
// - Fixed vector high bytes feed ID check
// - Relocatable table 256 bytes from base
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module icv_core
   import icv_pkg::*;
(
   input  logic        clk_sys_in,
   input  logic        resetn_in,
   input  logic        hsel_in,
   input  logic [31:0] haddr_in,
   input  logic [1:0]  htrans_in,
   input  logic        hwrite_in,
   input  logic [2:0]  hsize_in,
   input  logic [31:0] hwdata_in,
   input  logic        hready_in,
   output logic [31:0] hrdata_out,
   output logic        hreadyout_out,
   output logic        hresp_out,
   input  icv_core_s   core_in,
   input  icv_spec_s   spec_in,
   input  icv_periph_s periph_in,
   input  logic [31:0] mem_rdata_in,
   input  logic        mem_ack_in,
   input  logic [3:0]  id_slot_in,
   output logic        busy_out,
   output icv_ack_s    ack_out,
   output logic        u_flag_out,
   output logic        mem_req_out,
   output logic [19:0] mem_addr_out,
   output logic [19:0] id_addr_out
);

   typedef struct packed {
      icv_st_e     fsm;
      icv_src_e    src;
      logic [5:0]  num;
      logic        reloc_try;
      logic        push_u;
      logic        stacked_u;
      logic        mem_req;
      logic [19:0] mem_addr;
      icv_ack_s    ack;
      logic        u_flag;
      logic [1:0]  match_en;
      logic [19:0] madr0;
      logic [19:0] madr1;
      logic [19:0] tbase;
      logic [19:0] last_tgt;
      icv_src_e    last_src;
      logic [5:0]  last_num;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
      logic [19:0] id_addr;
   } icv_state_s;

   icv_state_s  st_r;
   icv_state_s  st_nxt;
   logic        dec_take;
   icv_src_e    dec_src;
   logic [19:0] dec_vec;
   logic [5:0]  dec_num;
   logic [6:0]  pf;
   logic        ahb_go;

   function automatic logic [19:0] fix_vec(input logic [3:0] slot);
      return FIX_BASE + {14'h0, slot, 2'b00};
   endfunction

   // Relocatable entry address relative to base
   function automatic logic [19:0] rel_vec(input logic [19:0] base, input logic [5:0] num);
      return base + {12'h0, num, 2'b00};
   endfunction

   // Highest level above IPL, lowest number on a tie
   function automatic logic [6:0] find_periph(input icv_periph_s p, input logic [2:0] ipl);
      logic [6:0] r;
      logic [2:0] best;
      r    = '0;
      best = ipl;
      for (int i = INT_SHARED_LO; i <= INT_SHARED_HI; i++) begin
         if (p.req[i] && (p.lvl[i] > best)) begin
            r    = {1'b1, 6'(i)};
            best = p.lvl[i];
         end
      end
      return r;
   endfunction

   // Register read mux
   function automatic logic [31:0] rd_mux(input icv_state_s s, input logic [7:0] a);
      logic [31:0] d;
      d = '0;
      unique case (a)
         OFS_MATCH_EN: d = {30'h0, s.match_en};
         OFS_MADR0:    d = {12'h0, s.madr0};
         OFS_MADR1:    d = {12'h0, s.madr1};
         OFS_TBASE:    d = {12'h0, s.tbase};
         OFS_LAST_TGT: d = {12'h0, s.last_tgt};
         OFS_LAST_SRC: d = {18'h0, s.last_num, 4'(s.last_src)};
         default:      d = '0;
      endcase
      return d;
   endfunction

   assign ahb_go = hsel_in && htrans_in[1] && hready_in;

   // Source classification at an instruction boundary
   always_comb begin
      dec_take = 1'b0;
      dec_src  = SRC_NONE;
      dec_vec  = '0;
      dec_num  = '0;
      pf       = find_periph(periph_in, core_in.ipl);
      if (st_r.fsm == ST_IDLE && core_in.boundary) begin
         dec_take = 1'b1;
         if (core_in.undefined_opcode_instr) begin
            dec_src = SRC_UND;
            dec_vec = fix_vec(SLOT_UND);
         end else if (core_in.into && core_in.ovf_flag) begin
            dec_src = SRC_OVF;
            dec_vec = fix_vec(SLOT_OVF);
         end else if (core_in.break_instr) begin
            dec_src = SRC_BRK;
            dec_vec = fix_vec(SLOT_BRK);
         end else if (core_in.int_op) begin
            dec_src = SRC_INT;
            dec_num = core_in.int_num;
            dec_vec = rel_vec(st_r.tbase, core_in.int_num);
         end else if ((st_r.match_en[0] && core_in.next_pc == st_r.madr0) ||
                      (st_r.match_en[1] && core_in.next_pc == st_r.madr1)) begin
            dec_src = SRC_MATCH;
            dec_vec = fix_vec(SLOT_MATCH);
         end else if (spec_in.wdt || spec_in.osc || spec_in.vmon) begin
            dec_src = SRC_SHARED;
            dec_vec = fix_vec(SLOT_SHARED);
         end else if (spec_in.step) begin
            dec_src = SRC_STEP;
            dec_vec = fix_vec(SLOT_STEP);
         end else if (spec_in.abrk) begin
            dec_src = SRC_ABRK;
            dec_vec = fix_vec(SLOT_ABRK);
         end else if (core_in.i_flag && pf[6]) begin
            dec_src = SRC_PERIPH;
            dec_num = pf[5:0];
            dec_vec = rel_vec(st_r.tbase, pf[5:0]);
         end else begin
            dec_take = 1'b0;
         end
      end
   end

   // Next-state: sequencer, U flag and register slave
   always_comb begin
      st_nxt           = st_r;
      st_nxt.ack.valid = 1'b0;
      unique case (st_r.fsm)
         ST_IDLE: begin
            if (dec_take) begin
               st_nxt.fsm       = ST_FETCH;
               st_nxt.src       = dec_src;
               st_nxt.num       = dec_num;
               st_nxt.mem_addr  = dec_vec;
               st_nxt.mem_req   = 1'b1;
               st_nxt.reloc_try = (dec_src == SRC_BRK);
               st_nxt.push_u    = 1'b0;
               st_nxt.stacked_u = st_r.u_flag;
               if (dec_src == SRC_INT && dec_num <= INT_USTACK_HI) begin
                  st_nxt.push_u = 1'b1;
                  st_nxt.u_flag = 1'b0;
               end
            end
         end
         ST_FETCH: begin
            if (mem_ack_in) begin
               if (st_r.reloc_try && mem_rdata_in[31:24] == BRK_RELOC_MRK) begin
                  st_nxt.reloc_try = 1'b0;
                  st_nxt.mem_addr  = rel_vec(st_r.tbase, BRK_REL_NUM);
               end else begin
                  st_nxt.fsm           = ST_ACK;
                  st_nxt.mem_req       = 1'b0;
                  st_nxt.ack.valid     = 1'b1;
                  st_nxt.ack.target    = mem_rdata_in[19:0];
                  st_nxt.ack.src       = st_r.src;
                  st_nxt.ack.num       = st_r.num;
                  st_nxt.ack.push_u    = st_r.push_u;
                  st_nxt.ack.stacked_u = st_r.stacked_u;
                  st_nxt.last_tgt      = mem_rdata_in[19:0];
                  st_nxt.last_src      = st_r.src;
                  st_nxt.last_num      = st_r.num;
               end
            end
         end
         ST_ACK: begin
            st_nxt.fsm = ST_IDLE;
         end
      endcase
      if (core_in.reti) begin
         st_nxt.u_flag = core_in.stacked_u;
      end else if (core_in.u_wr && st_r.fsm == ST_IDLE && !dec_take) begin
         st_nxt.u_flag = core_in.u_wdata;
      end
      // Data phase of a write
      if (st_r.wr_pend) begin
         unique case (st_r.wr_addr)
            OFS_MATCH_EN: st_nxt.match_en = hwdata_in[1:0];
            OFS_MADR0:    st_nxt.madr0    = hwdata_in[19:0];
            OFS_MADR1:    st_nxt.madr1    = hwdata_in[19:0];
            OFS_TBASE:    st_nxt.tbase    = hwdata_in[19:0];
            default:      st_nxt.wr_pend  = 1'b0;
         endcase
      end
      // Address phase; read sees a write just done
      st_nxt.wr_pend = ahb_go && hwrite_in;
      st_nxt.wr_addr = haddr_in[7:0];
      if (ahb_go && !hwrite_in) begin
         st_nxt.rdata = (haddr_in[31:8] == 24'h0) ? rd_mux(st_nxt, haddr_in[7:0]) : 32'h0;
      end
      // high byte of chosen fixed slot
      st_nxt.id_addr = fix_vec(id_slot_in) + {18'h0, VEC_HI_BYTE};
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_r          <= '0;
         st_r.fsm      <= ST_IDLE;
         st_r.src      <= SRC_NONE;
         st_r.last_src <= SRC_NONE;
         st_r.u_flag   <= RST_U_FLAG;
         st_r.match_en <= RST_MATCH_EN;
         st_r.madr0    <= RST_ADDR;
         st_r.madr1    <= RST_ADDR;
         st_r.tbase    <= RST_ADDR;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign hrdata_out    = st_r.rdata;
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
   assign busy_out      = (st_r.fsm != ST_IDLE);
   assign ack_out       = st_r.ack;
   assign u_flag_out    = st_r.u_flag;
   assign mem_req_out   = st_r.mem_req;
   assign mem_addr_out  = st_r.mem_addr;
   assign id_addr_out   = st_r.id_addr;

   // Checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);

   property p_mask;
      dec_take && dec_src == SRC_PERIPH |-> core_in.i_flag && pf[6];
   endproperty
   a_mask: assert property (p_mask) else $error("maskable taken with I clear");

   property p_nmi;
      st_r.fsm == ST_IDLE && core_in.boundary && spec_in.wdt && !core_in.i_flag
         |=> st_r.fsm == ST_FETCH;
   endproperty
   a_nmi: assert property (p_nmi) else $error("special request not taken");

   property p_und;
      st_r.fsm == ST_IDLE && core_in.boundary && core_in.undefined_opcode_instr
         |=> st_r.mem_addr == FIX_BASE && st_r.mem_req;
   endproperty
   a_und: assert property (p_und) else $error("undefined opcode slot wrong");

   property p_ovf;
      dec_take && dec_src == SRC_OVF |-> core_in.into && core_in.ovf_flag;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow trap without flag");

   property p_brk;
      st_r.fsm == ST_FETCH && mem_ack_in && st_r.reloc_try && mem_rdata_in[31:24] == BRK_RELOC_MRK
         |=> st_r.mem_addr == st_r.tbase && st_r.mem_req && st_r.fsm == ST_FETCH;
   endproperty
   a_brk: assert property (p_brk) else $error("break redirect missing");

   property p_int;
      st_r.fsm == ST_IDLE && core_in.boundary && core_in.int_op && !core_in.undefined_opcode_instr && !core_in.break_instr
         && !(core_in.into && core_in.ovf_flag)
         |=> st_r.mem_addr == rel_vec($past(st_r.tbase), $past(core_in.int_num));
   endproperty
   a_int: assert property (p_int) else $error("software entry address wrong");

   property p_ulow;
      st_nxt.ack.valid && st_r.src == SRC_INT && st_r.num <= INT_USTACK_HI
         |=> ack_out.push_u && !u_flag_out ##1 st_r.fsm == ST_IDLE;
   endproperty
   a_ulow: assert property (p_ulow) else $error("U not pushed or cleared");

   property p_uhigh;
      dec_take && dec_src == SRC_INT && dec_num > INT_USTACK_HI && !core_in.reti
         |=> u_flag_out == $past(u_flag_out) && !st_r.push_u;
   endproperty
   a_uhigh: assert property (p_uhigh) else $error("U changed for high number");

   property p_reti;
      core_in.reti |=> u_flag_out == $past(core_in.stacked_u);
   endproperty
   a_reti: assert property (p_reti) else $error("U not restored");

   property p_vec;
      st_r.fsm == ST_FETCH && mem_ack_in && !st_r.reloc_try
         |=> ack_out.valid && ack_out.target == $past(mem_rdata_in[19:0]) ##1 !ack_out.valid;
   endproperty
   a_vec: assert property (p_vec) else $error("branch target not from vector");

   property p_brkslot;
      st_r.fsm == ST_IDLE && core_in.boundary && core_in.break_instr && !core_in.undefined_opcode_instr
         && !(core_in.into && core_in.ovf_flag)
         |=> st_r.mem_addr == FIX_BASE + 20'h00008 && st_r.fsm == ST_FETCH;
   endproperty
   a_brkslot: assert property (p_brkslot) else $error("break slot wrong");

   property p_shared;
      dec_take && dec_src == SRC_SHARED
         |=> st_r.mem_addr == FIX_BASE + 20'h00014 && st_r.mem_req;
   endproperty
   a_shared: assert property (p_shared) else $error("shared special slot wrong");

   property p_match;
      st_r.fsm == ST_IDLE && core_in.boundary && !core_in.undefined_opcode_instr && !core_in.into && !core_in.break_instr
         && !core_in.int_op && st_r.match_en[0] && core_in.next_pc == st_r.madr0
         |=> st_r.mem_addr == FIX_BASE + 20'h0000C && st_r.fsm == ST_FETCH;
   endproperty
   a_match: assert property (p_match) else $error("address match not taken");

   property p_nobound;
      st_r.fsm == ST_IDLE && !core_in.boundary |=> st_r.fsm == ST_IDLE;
   endproperty
   a_nobound: assert property (p_nobound) else $error("taken off a boundary");

endmodule // icv_core

// >>> hw/icv_pkg.sv
// Package: constants, types and carriers of the interrupt class and vector block
package icv_pkg;
   // Fixed vector table and slot numbers
   localparam logic [19:0] FIX_BASE      = 20'hFFDC;
   localparam logic [19:0] FIX_TOP       = 20'hFFFF;
   localparam logic [3:0]  SLOT_UND      = 4'h0;
   localparam logic [3:0]  SLOT_OVF      = 4'h1;
   localparam logic [3:0]  SLOT_BRK      = 4'h2;
   localparam logic [3:0]  SLOT_MATCH    = 4'h3;
   localparam logic [3:0]  SLOT_STEP     = 4'h4;
   localparam logic [3:0]  SLOT_SHARED   = 4'h5;
   localparam logic [3:0]  SLOT_ABRK     = 4'h6;
   localparam logic [1:0]  VEC_HI_BYTE   = 2'h3;
   localparam logic [7:0]  BRK_RELOC_MRK = 8'hFF;
   // Relocatable table and software interrupt number ranges
   localparam int          REL_SPAN      = 256;
   localparam int          INT_SHARED_LO = 4;
   localparam int          INT_SHARED_HI = 31;
   localparam logic [5:0]  INT_USTACK_HI = 6'h1F;
   localparam logic [5:0]  BRK_REL_NUM   = 6'h00;
   // Register byte offsets
   localparam logic [7:0]  OFS_MATCH_EN  = 8'h00;
   localparam logic [7:0]  OFS_MADR0     = 8'h04;
   localparam logic [7:0]  OFS_MADR1     = 8'h08;
   localparam logic [7:0]  OFS_TBASE     = 8'h0C;
   localparam logic [7:0]  OFS_LAST_TGT  = 8'h10;
   localparam logic [7:0]  OFS_LAST_SRC  = 8'h14;
   // Reset values
   localparam logic [1:0]  RST_MATCH_EN  = 2'h0;
   localparam logic [19:0] RST_ADDR      = 20'h00000;
   localparam logic        RST_U_FLAG    = 1'b0;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_ACK} icv_st_e;
   typedef enum logic [3:0] {SRC_NONE, SRC_UND, SRC_OVF, SRC_BRK, SRC_INT, SRC_MATCH,
                             SRC_STEP, SRC_SHARED, SRC_ABRK, SRC_PERIPH} icv_src_e;

   // Core events; decode inputs sampled at instruction boundaries, reti and U writes also between them
   typedef struct packed {
      logic        boundary;
      logic        undefined_opcode_instr;
      logic        into;
      logic        ovf_flag;
      logic        break_instr;
      logic        int_op;
      logic [5:0]  int_num;
      logic [19:0] next_pc;
      logic        i_flag;
      logic [2:0]  ipl;
      logic        reti;
      logic        stacked_u;
      logic        u_wr;
      logic        u_wdata;
   } icv_core_s;

   typedef struct packed {
      logic wdt;
      logic osc;
      logic vmon;
      logic step;
      logic abrk;
   } icv_spec_s;

   typedef struct packed {
      logic [31:0]      req;
      logic [31:0][2:0] lvl;
   } icv_periph_s;

   typedef struct packed {
      logic        valid;
      logic [19:0] target;
      icv_src_e    src;
      logic [5:0]  num;
      logic        push_u;
      logic        stacked_u;
   } icv_ack_s;
endpackage

// >>> tb/icv_vmem_model.sv
// Vector memory model that answers the block's vector fetches
`timescale 1ns/1ps
module icv_vmem_model
   import icv_pkg::*;
(
   input  logic        clk_sys_in,
   input  logic        resetn_in,
   input  logic        mem_req_in,
   input  logic [19:0] mem_addr_in,
   input  logic        brk_ff_in,
   input  logic        slow_in,
   output logic [31:0] mem_rdata_out,
   output logic        mem_ack_out
);
   logic [1:0] wait_r;

   // Answer at once or after three idle cycles; idle data toggles
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wait_r        <= 2'h0;
         mem_ack_out   <= 1'b0;
         mem_rdata_out <= 32'h0000_0000;
      end else begin
         mem_ack_out   <= 1'b0;
         mem_rdata_out <= ~mem_rdata_out;
         if (mem_req_in && !mem_ack_out) begin
            if (!slow_in || wait_r == 2'h3) begin
               mem_ack_out   <= 1'b1;
               wait_r        <= 2'h0;
               // word holds start address, FFh marker on break slot
               mem_rdata_out <= {(brk_ff_in && mem_addr_in == 20'h0FFE4) ? BRK_RELOC_MRK : 8'h00,
                                 4'h0, mem_addr_in + 20'h01000};
            end else begin
               wait_r <= wait_r + 2'h1;
            end
         end
      end
   end
endmodule // icv_vmem_model

// >>> tb/test_interrupt_class_vectoring.sv
// Self-checking bench for the interrupt class and vector block
`timescale 1ns/1ps
module test_interrupt_class_vectoring
   import icv_pkg::*;
();
   localparam logic [19:0] BASE = 20'h0C000;
   typedef struct packed {
      logic [3:0]  k;
      logic [4:0]  sp;
      logic [5:0]  n;
      logic [19:0] va;
      icv_src_e    src;
   } icv_row_s;
   logic        clk_sys_in;
   logic        resetn_in;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hrdy;
   logic [31:0] hrdata;
   icv_core_s   core;
   icv_spec_s   spec;
   icv_periph_s per;
   logic [31:0] m_rdata;
   logic        m_ack;
   logic [3:0]  id_slot;
   logic        busy;
   icv_ack_s    ack;
   icv_ack_s    ack_q;
   logic        u_flag;
   logic        m_req;
   logic [19:0] m_addr;
   logic [19:0] id_addr;
   logic        brk_ff;
   logic        slow;
   logic [31:0] rd;
   int          n_ack = 0;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   icv_row_s    rows [14] = '{
      '{4'h8, 5'h00, 6'h00, 20'h0FFDC, SRC_UND}, '{4'h4, 5'h00, 6'h00, 20'h0FFE0, SRC_OVF},
      '{4'h2, 5'h00, 6'h00, 20'h0FFE4, SRC_BRK}, '{4'h1, 5'h00, 6'h00, 20'h00000, SRC_INT},
      '{4'h1, 5'h00, 6'h04, 20'h00000, SRC_INT}, '{4'h1, 5'h00, 6'h1F, 20'h00000, SRC_INT},
      '{4'h1, 5'h00, 6'h20, 20'h00000, SRC_INT}, '{4'h1, 5'h00, 6'h3F, 20'h00000, SRC_INT},
      '{4'h0, 5'h10, 6'h00, 20'h0FFF0, SRC_SHARED}, '{4'h0, 5'h08, 6'h00, 20'h0FFF0, SRC_SHARED},
      '{4'h0, 5'h04, 6'h00, 20'h0FFF0, SRC_SHARED}, '{4'h0, 5'h02, 6'h00, 20'h0FFEC, SRC_STEP},
      '{4'h0, 5'h01, 6'h00, 20'h0FFF4, SRC_ABRK}, '{4'h8, 5'h10, 6'h00, 20'h0FFDC, SRC_UND}};

   icv_core dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(), .core_in(core), .spec_in(spec),
      .periph_in(per), .mem_rdata_in(m_rdata), .mem_ack_in(m_ack), .id_slot_in(id_slot),
      .busy_out(busy), .ack_out(ack), .u_flag_out(u_flag), .mem_req_out(m_req),
      .mem_addr_out(m_addr), .id_addr_out(id_addr));
   icv_vmem_model vmem (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .mem_req_in(m_req),
      .mem_addr_in(m_addr), .brk_ff_in(brk_ff), .slow_in(slow), .mem_rdata_out(m_rdata),
      .mem_ack_out(m_ack));

   // Clock
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   // Latch each acknowledge pulse
   always @(posedge clk_sys_in) begin
      if (ack.valid === 1'b1) begin
         ack_q <= ack;
         n_ack <= n_ack + 1;
      end
   end

   task automatic report_and_stop();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         n_mismatch++;
      end
   endtask

   // Single word bus transfer; read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk_sys_in);
      while (hrdy !== 1'b1) @(posedge clk_sys_in);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys_in);
      while (hrdy !== 1'b1) @(posedge clk_sys_in);
      rd = hrdata;
   endtask

   // One boundary with events; checks the acknowledge or its absence
   task automatic ev(input logic [3:0] k, input logic [4:0] sp, input logic [5:0] n,
                     input logic [19:0] pc, input logic [19:0] va, input icv_src_e src);
      int i;
      int a0;
      a0 = n_ack;
      @(posedge clk_sys_in);
      core.boundary <= 1'b1;
      {core.undefined_opcode_instr, core.into, core.break_instr, core.int_op} <= k;
      core.int_num <= n;
      core.next_pc <= pc;
      spec <= sp;
      @(posedge clk_sys_in);
      core.boundary <= 1'b0;
      {core.undefined_opcode_instr, core.into, core.break_instr, core.int_op} <= 4'h0;
      for (i = 0; i < 40 && n_ack == a0; i++) @(posedge clk_sys_in);
      spec <= '0;
      per.req <= '0;
      repeat (2) @(posedge clk_sys_in);
      chk(n_ack - a0, src != SRC_NONE);
      chk(busy, 1'b0);
      if (src != SRC_NONE) begin
         chk(ack_q.target, va + 20'h01000);
         chk(ack_q.src, src);
         if (src inside {SRC_INT, SRC_PERIPH}) chk(ack_q.num, n);
         bus(1'b0, OFS_LAST_TGT, 32'h0);
         chk(rd, va + 20'h01000);
         bus(1'b0, OFS_LAST_SRC, 32'h0);
         chk(rd[3:0], src);
      end
   endtask

   // Hang guard
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      int r;
      int s;
      logic [19:0] va;
      resetn_in = 1'b0;
      {hsel, hwrite, brk_ff, slow} = 4'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'h0;
      core = '0;
      spec = '0;
      per = '0;
      id_slot = 4'h0;
      repeat (4) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      for (r = 0; r <= 32; r += 4) begin
         bus(1'b0, r[7:0], 32'h0);
         chk(rd, 32'h0);
      end
      bus(1'b1, OFS_LAST_TGT, 32'h12345);
      bus(1'b0, OFS_LAST_TGT, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, OFS_TBASE, {12'h000, BASE});
      bus(1'b0, OFS_TBASE, 32'h0);
      chk(rd, {12'h000, BASE});
      core.ovf_flag <= 1'b1;
      for (r = 0; r < 14; r++) begin
         slow <= r[0];
         core.u_wr <= 1'b1;
         core.u_wdata <= 1'b1;
         @(posedge clk_sys_in);
         core.u_wr <= 1'b0;
         va = (rows[r].k == 4'h1) ? BASE + {12'h000, rows[r].n, 2'h0} : rows[r].va;
         ev(rows[r].k, rows[r].sp, rows[r].n, 20'h0, va, rows[r].src);
         if (rows[r].k == 4'h1) begin
            chk(ack_q.push_u, rows[r].n <= 6'h1F);
            chk(u_flag, rows[r].n > 6'h1F);
         end
      end
      core.ovf_flag <= 1'b0;
      ev(4'h4, 5'h00, 6'h00, 20'h0, 20'h0, SRC_NONE);
      brk_ff <= 1'b1;
      ev(4'h2, 5'h00, 6'h00, 20'h0, BASE, SRC_BRK);
      brk_ff <= 1'b0;
      ev(4'h1, 5'h00, 6'h03, 20'h0, BASE + 20'h0000C, SRC_INT);
      chk(u_flag, 1'b0);
      core.reti <= 1'b1;
      core.stacked_u <= 1'b1;
      @(posedge clk_sys_in);
      core.reti <= 1'b0;
      @(posedge clk_sys_in);
      chk(u_flag, 1'b1);
      core.ipl <= 3'h2;
      per.lvl[7] <= 3'h3;
      per.lvl[5] <= 3'h3;
      per.req <= 32'h0000_0080;
      ev(4'h0, 5'h00, 6'h07, 20'h0, 20'h0, SRC_NONE);
      core.i_flag <= 1'b1;
      per.req <= 32'h0000_0080;
      ev(4'h0, 5'h00, 6'h07, 20'h0, BASE + 20'h0001C, SRC_PERIPH);
      per.req <= 32'h0000_00A0;
      ev(4'h0, 5'h00, 6'h05, 20'h0, BASE + 20'h00014, SRC_PERIPH);
      per.lvl[5] <= 3'h2;
      per.req <= 32'h0000_00A0;
      ev(4'h0, 5'h00, 6'h07, 20'h0, BASE + 20'h0001C, SRC_PERIPH);
      core.i_flag <= 1'b0;
      bus(1'b1, OFS_MADR0, 32'h01234);
      bus(1'b1, OFS_MADR1, 32'h05678);
      ev(4'h0, 5'h00, 6'h00, 20'h01234, 20'h0, SRC_NONE);
      bus(1'b1, OFS_MATCH_EN, 32'h1);
      ev(4'h0, 5'h00, 6'h00, 20'h01234, 20'h0FFE8, SRC_MATCH);
      ev(4'h0, 5'h00, 6'h00, 20'h05678, 20'h0, SRC_NONE);
      bus(1'b1, OFS_MATCH_EN, 32'h2);
      ev(4'h0, 5'h00, 6'h00, 20'h05678, 20'h0FFE8, SRC_MATCH);
      for (s = 0; s < 9; s++) begin
         id_slot <= s[3:0];
         repeat (2) @(posedge clk_sys_in);
         chk(id_addr, FIX_BASE + 20'h3 + {14'h0, s[3:0], 2'h0});
      end
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      chk(u_flag, 1'b0);
      resetn_in <= 1'b1;
      bus(1'b0, OFS_MATCH_EN, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, OFS_TBASE, 32'h0);
      chk(rd, 32'h0);
      report_and_stop();
   end
endmodule // test_interrupt_class_vectoring
